/* verilog/mrr_pkg.sv */
/*
 * Package of the measurement result register bank: register indices, field
 * layout, reset values, result-delivery carrier and scan states.
 * Assumes an APB master with 32-bit data and byte addressing.
 */
package mrr_pkg;

  // ==========================================================================
  // Register indices (byte address is four times the index)
  localparam logic [9:0] IDX_CELL_THIRTEEN_CODE     = 10'h053;
  localparam logic [9:0] IDX_CELL_FOURTEEN_CODE     = 10'h054;
  localparam logic [9:0] IDX_BLOCK      = 10'h055;
  localparam logic [9:0] IDX_TOTAL      = 10'h056;
  localparam logic [9:0] IDX_DIAGNOSTIC_CODE_FIRST      = 10'h057;
  localparam logic [9:0] IDX_DIAGNOSTIC_CODE_SECOND      = 10'h058;
  localparam logic [9:0] IDX_MEAS_EN    = 10'h060;
  localparam logic [9:0] IDX_CONFIG     = 10'h061;
  localparam logic [9:0] IDX_STATUS     = 10'h062;

  // ==========================================================================
  // Field layout
  localparam int         CODE_W         = 14;
  localparam int         CODE_LSB       = 2;
  localparam int         TOTAL_W        = 16;
  localparam int         ACC_W          = 20;
  localparam int         NUM_CELLS      = 14;
  localparam logic [3:0] CHAN_CELL_THIRTEEN_CODE    = 4'hc;
  localparam logic [3:0] CHAN_CELL_FOURTEEN_CODE    = 4'hd;
  localparam int         BLOCK_EN_BIT   = 15;
  localparam int         FILTERED_READBACK_SELECT_BIT     = 0;
  localparam int         DSEL1_LSB      = 4;
  localparam int         DSEL2_LSB      = 8;
  localparam int         DSEL_W         = 4;
  // Total LSB is four cell LSBs: 5 V / 2^14 against 80 V / 2^16
  localparam int         TOTAL_SHIFT    = 2;

  // ==========================================================================
  // Reset values
  localparam logic [15:0] RESULT_RST    = 16'h0000;
  localparam logic [15:0] MEAS_EN_RST   = 16'h0000;
  localparam logic [15:0] CONFIG_RST    = 16'h0000;

  // ==========================================================================
  // Result carrier from the acquisition engine
  typedef enum logic [1:0] {
    KIND_CELL  = 2'h0,
    KIND_BLOCK = 2'h1,
    KIND_DIAGNOSTIC_CODE_FIRST = 2'h2,
    KIND_DIAGNOSTIC_CODE_SECOND = 2'h3
  } mrr_kind_e;

  typedef struct packed {
    mrr_kind_e         kind;
    logic [3:0]        chan;
    logic [CODE_W-1:0] raw;
    logic [CODE_W-1:0] filt;
    logic              bipolar;
    logic              current_sense_amplifier;
  } mrr_res_s;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_SCAN = 1'b1
  } mrr_state_e;

endpackage

/* verilog/mrr_result_regs.sv */
/*
 * Measurement result register bank: last two cell results, block voltage,
 * summed cell voltage and two diagnostic results, read over APB.
 * Assumes the acquisition engine on pclk brackets each scan with
 * scan_start and scan_done pulses and delivers results between them.
 */
// Behaviour
// - Cell code sits in bits 15:2.
// - Cell code spans five volts full scale.
// - Skipped disabled cell keeps old result.
// - Readback select picks raw or filtered.
// - Block code in 15:2, 65 V scale.
// - Skipped disabled block keeps old result.
// - Sixteen-bit sum of enabled cell results.
// - Sum unsigned, 1.22 mV step, 80 V.
// - Sum only this scan's measured channels.
// - Each result summed by its own signedness.
// - Current-sense results never enter sum.
// - Negative sum clips to zero.
// - First diagnostic result in 15:2.
// - Second diagnostic result in 15:2.
// - Results read-only, reset zero, ignore writes.
`timescale 1ns/1ps
module mrr_result_regs (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Acquisition engine
  input  wire logic              scan_start,
  input  wire logic              scan_done,
  input  wire logic              res_valid,
  input  wire mrr_pkg::mrr_res_s res_data,
  // Configuration towards the engine
  output logic [15:0]            measure_enable_first,
  output logic [3:0]             diagnostic_select_first,
  output logic [3:0]             diagnostic_select_second
);

  // ==========================================================================
  // Storage
  logic [mrr_pkg::CODE_W-1:0]  cell_thirteen_code_raw_r, cell_thirteen_code_filt_r;
  logic [mrr_pkg::CODE_W-1:0]  cell_fourteen_code_raw_r, cell_fourteen_code_filt_r;
  logic [mrr_pkg::CODE_W-1:0]  block_raw_r, block_filt_r;
  logic [mrr_pkg::CODE_W-1:0]  diagnostic_code_first_r, diagnostic_code_second_r;
  logic [mrr_pkg::TOTAL_W-1:0] total_r;
  logic signed [mrr_pkg::ACC_W-1:0] acc_r, acc_nxt;
  logic [15:0]                 meas_en_r;
  logic [15:0]                 config_r;
  logic                        clipped_r;
  logic [7:0]                  scan_cnt_r;
  mrr_pkg::mrr_state_e         state_r;
  logic [31:0]                 prdata_r;
  logic                        pready_r;
  logic                        pslverr_r;

  logic [9:0]  idx;
  logic        access;
  logic        wr_take;
  logic        cell_en;
  logic        filtered_readback_select;
  logic        sum_take;
  logic signed [mrr_pkg::ACC_W-1:0] term;
  logic [mrr_pkg::TOTAL_W-1:0] total_nxt;
  logic        clip_nxt;
  logic [31:0] rd_val;
  logic        rd_err;

  assign idx     = paddr[11:2];
  assign access  = psel & penable;
  assign wr_take = access & pready_r & pwrite & ~pslverr_r;
  assign cell_en = meas_en_r[res_data.chan];
  assign filtered_readback_select  = config_r[mrr_pkg::FILTERED_READBACK_SELECT_BIT];

  // ==========================================================================
  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meas_en_r <= mrr_pkg::MEAS_EN_RST;
      config_r  <= mrr_pkg::CONFIG_RST;
    end else if (wr_take) begin
      if (idx == mrr_pkg::IDX_MEAS_EN) begin
        meas_en_r <= pwdata[15:0];
      end
      if (idx == mrr_pkg::IDX_CONFIG) begin
        config_r <= {4'h0, pwdata[11:8], pwdata[7:4], 3'h0, pwdata[0]};
      end
    end
  end

  // ==========================================================================
  // Cell and block results; no bus path writes here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cell_thirteen_code_raw_r  <= '0;
      cell_thirteen_code_filt_r <= '0;
      cell_fourteen_code_raw_r  <= '0;
      cell_fourteen_code_filt_r <= '0;
      block_raw_r   <= '0;
      block_filt_r  <= '0;
    end else if (res_valid) begin
      // Disabled channels keep their old codes
      if (res_data.kind == mrr_pkg::KIND_CELL && cell_en && !res_data.current_sense_amplifier) begin
        if (res_data.chan == mrr_pkg::CHAN_CELL_THIRTEEN_CODE) begin
          cell_thirteen_code_raw_r  <= res_data.raw;
          cell_thirteen_code_filt_r <= res_data.filt;
        end
        if (res_data.chan == mrr_pkg::CHAN_CELL_FOURTEEN_CODE) begin
          cell_fourteen_code_raw_r  <= res_data.raw;
          cell_fourteen_code_filt_r <= res_data.filt;
        end
      end
      if (res_data.kind == mrr_pkg::KIND_BLOCK && meas_en_r[mrr_pkg::BLOCK_EN_BIT]) begin
        block_raw_r  <= res_data.raw;
        block_filt_r <= res_data.filt;
      end
    end
  end

  // ==========================================================================
  // Diagnostic results
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      diagnostic_code_first_r <= '0;
      diagnostic_code_second_r <= '0;
    end else if (res_valid) begin
      if (res_data.kind == mrr_pkg::KIND_DIAGNOSTIC_CODE_FIRST) begin
        diagnostic_code_first_r <= res_data.raw;
      end
      if (res_data.kind == mrr_pkg::KIND_DIAGNOSTIC_CODE_SECOND) begin
        diagnostic_code_second_r <= res_data.raw;
      end
    end
  end

  // ==========================================================================
  // Sum of enabled cells, in cell LSB units until the final scaling
  assign sum_take = res_valid && res_data.kind == mrr_pkg::KIND_CELL && cell_en
                    && !res_data.current_sense_amplifier && res_data.chan < 4'(mrr_pkg::NUM_CELLS);

  always_comb begin
    // Bus-bar codes are two's complement, cell codes unsigned
    if (res_data.bipolar) begin
      term = {{(mrr_pkg::ACC_W-mrr_pkg::CODE_W){res_data.raw[mrr_pkg::CODE_W-1]}}, res_data.raw};
    end else begin
      term = {{(mrr_pkg::ACC_W-mrr_pkg::CODE_W){1'b0}}, res_data.raw};
    end
  end

  always_comb begin
    acc_nxt = acc_r;
    if (scan_start) begin
      acc_nxt = '0;
    end else if (sum_take) begin
      acc_nxt = acc_r + term;
    end
  end

  always_comb begin
    clip_nxt = 1'b0;
    if (acc_nxt[mrr_pkg::ACC_W-1]) begin
      total_nxt = '0;
      clip_nxt  = 1'b1;
    end else if (acc_nxt[mrr_pkg::ACC_W-2]) begin
      // Beyond 80 V only on out-of-range codes; saturate rather than wrap
      total_nxt = '1;
    end else begin
      total_nxt = acc_nxt[mrr_pkg::TOTAL_W+mrr_pkg::TOTAL_SHIFT-1:mrr_pkg::TOTAL_SHIFT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_r <= '0;
    end else begin
      acc_r <= acc_nxt;
    end
  end

  // Total only moves at scan end, so readers never see a partial sum
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      total_r   <= mrr_pkg::RESULT_RST;
      clipped_r <= 1'b0;
    end else if (scan_done) begin
      total_r   <= total_nxt;
      clipped_r <= clip_nxt;
    end
  end

  // ==========================================================================
  // Scan tracking
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r    <= mrr_pkg::ST_IDLE;
      scan_cnt_r <= 8'h00;
    end else begin
      case (state_r)
        mrr_pkg::ST_IDLE: begin
          if (scan_start) begin
            state_r <= mrr_pkg::ST_SCAN;
          end
        end
        mrr_pkg::ST_SCAN: begin
          if (scan_done) begin
            state_r    <= mrr_pkg::ST_IDLE;
            scan_cnt_r <= scan_cnt_r + 8'h01;
          end
        end
        default: begin
          state_r <= mrr_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Read mux
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_err = 1'b0;
    case (idx)
      mrr_pkg::IDX_CELL_THIRTEEN_CODE: rd_val = {16'h0000, filtered_readback_select ? cell_thirteen_code_filt_r : cell_thirteen_code_raw_r, 2'b00};
      mrr_pkg::IDX_CELL_FOURTEEN_CODE: rd_val = {16'h0000, filtered_readback_select ? cell_fourteen_code_filt_r : cell_fourteen_code_raw_r, 2'b00};
      mrr_pkg::IDX_BLOCK:  rd_val = {16'h0000, filtered_readback_select ? block_filt_r : block_raw_r, 2'b00};
      mrr_pkg::IDX_TOTAL:  rd_val = {16'h0000, total_r};
      mrr_pkg::IDX_DIAGNOSTIC_CODE_FIRST:  rd_val = {16'h0000, diagnostic_code_first_r, 2'b00};
      mrr_pkg::IDX_DIAGNOSTIC_CODE_SECOND:  rd_val = {16'h0000, diagnostic_code_second_r, 2'b00};
      mrr_pkg::IDX_MEAS_EN: rd_val = {16'h0000, meas_en_r};
      mrr_pkg::IDX_CONFIG:  rd_val = {16'h0000, config_r};
      mrr_pkg::IDX_STATUS:  rd_val = {16'h0000, scan_cnt_r, 6'h00, clipped_r, state_r == mrr_pkg::ST_SCAN};
      default:              rd_err = 1'b1;
    endcase
    if (paddr[1:0] != 2'b00) begin
      rd_err = 1'b1;
    end
  end

  // ==========================================================================
  // APB answer: one wait state, result writes dropped silently
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= access & ~pready_r;
      pslverr_r <= access & ~pready_r & rd_err;
      if (access && !pready_r && !pwrite && !rd_err) begin
        prdata_r <= rd_val;
      end else begin
        prdata_r <= 32'h0000_0000;
      end
    end
  end

  assign prdata                   = prdata_r;
  assign pready                   = pready_r;
  assign pslverr                  = pslverr_r;
  assign measure_enable_first     = meas_en_r;
  assign diagnostic_select_first  = config_r[mrr_pkg::DSEL1_LSB +: mrr_pkg::DSEL_W];
  assign diagnostic_select_second = config_r[mrr_pkg::DSEL2_LSB +: mrr_pkg::DSEL_W];

  // ==========================================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic rd_take;
  assign rd_take = access & pready_r & ~pwrite & ~pslverr_r;

  property p_cell_thirteen_code_update;
    res_valid && res_data.kind == mrr_pkg::KIND_CELL && res_data.chan == mrr_pkg::CHAN_CELL_THIRTEEN_CODE
      && cell_en && !res_data.current_sense_amplifier |=> cell_thirteen_code_raw_r == $past(res_data.raw);
  endproperty
  a_cell_thirteen_code_update: assert property (p_cell_thirteen_code_update) else $error("cell_thirteen_code not stored");

  property p_cell_skip;
    res_valid && res_data.kind == mrr_pkg::KIND_CELL && !cell_en
      |=> $stable(cell_thirteen_code_raw_r) && $stable(cell_fourteen_code_raw_r);
  endproperty
  a_cell_skip: assert property (p_cell_skip) else $error("disabled cell overwritten");

  property p_filtered_readback_select;
    // A result landing in the same cycle would move the register under the captured word
    access && !pready_r && !pwrite && idx == mrr_pkg::IDX_CELL_FOURTEEN_CODE && paddr[1:0] == 2'b00 && !res_valid
      |=> prdata[15:2] == (filtered_readback_select ? cell_fourteen_code_filt_r : cell_fourteen_code_raw_r);
  endproperty
  a_filtered_readback_select: assert property (p_filtered_readback_select) else $error("readback select ignored");

  property p_block_skip;
    res_valid && res_data.kind == mrr_pkg::KIND_BLOCK && !meas_en_r[mrr_pkg::BLOCK_EN_BIT]
      |=> $stable(block_raw_r) && $stable(block_filt_r);
  endproperty
  a_block_skip: assert property (p_block_skip) else $error("disabled block overwritten");

  property p_scan_clear;
    scan_start && !scan_done |=> acc_r == '0;
  endproperty
  a_scan_clear: assert property (p_scan_clear) else $error("sum not cleared at scan start");

  property p_csa_excluded;
    res_valid && res_data.current_sense_amplifier && !scan_start |=> acc_r == $past(acc_r);
  endproperty
  a_csa_excluded: assert property (p_csa_excluded) else $error("current sense summed");

  property p_clip;
    scan_done && acc_nxt[mrr_pkg::ACC_W-1] |=> total_r == 16'h0000 && clipped_r;
  endproperty
  a_clip: assert property (p_clip) else $error("negative total not clipped");

  property p_diagnostic_code_second;
    res_valid && res_data.kind == mrr_pkg::KIND_DIAGNOSTIC_CODE_SECOND |=> diagnostic_code_second_r == $past(res_data.raw);
  endproperty
  a_diagnostic_code_second: assert property (p_diagnostic_code_second) else $error("diagnostic_code_second not stored");

  property p_ro_write;
    wr_take && idx >= mrr_pkg::IDX_CELL_THIRTEEN_CODE && idx <= mrr_pkg::IDX_DIAGNOSTIC_CODE_SECOND && !res_valid && !scan_done
      |=> $stable(cell_thirteen_code_raw_r) && $stable(total_r) && $stable(diagnostic_code_first_r);
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("result register written");

  property p_low_bits;
    rd_take && idx != mrr_pkg::IDX_TOTAL && idx >= mrr_pkg::IDX_CELL_THIRTEEN_CODE && idx <= mrr_pkg::IDX_DIAGNOSTIC_CODE_SECOND
      |-> prdata[1:0] == 2'b00 && prdata[31:16] == 16'h0000;
  endproperty
  a_low_bits: assert property (p_low_bits) else $error("low result bits not zero");

  property p_answer;
    access && !pready_r |=> pready_r ##1 !pready_r;
  endproperty
  a_answer: assert property (p_answer) else $error("apb answer timing wrong");

  property p_cell_fourteen_code_update;
    res_valid && res_data.kind == mrr_pkg::KIND_CELL && res_data.chan == mrr_pkg::CHAN_CELL_FOURTEEN_CODE
      && cell_en && !res_data.current_sense_amplifier |=> cell_fourteen_code_raw_r == $past(res_data.raw) && cell_fourteen_code_filt_r == $past(res_data.filt);
  endproperty
  a_cell_fourteen_code_update: assert property (p_cell_fourteen_code_update) else $error("cell_fourteen_code not stored");

  property p_block_update;
    res_valid && res_data.kind == mrr_pkg::KIND_BLOCK && meas_en_r[mrr_pkg::BLOCK_EN_BIT]
      |=> block_raw_r == $past(res_data.raw) && block_filt_r == $past(res_data.filt);
  endproperty
  a_block_update: assert property (p_block_update) else $error("block result not stored");

  property p_diagnostic_code_first;
    res_valid && res_data.kind == mrr_pkg::KIND_DIAGNOSTIC_CODE_FIRST |=> diagnostic_code_first_r == $past(res_data.raw);
  endproperty
  a_diagnostic_code_first: assert property (p_diagnostic_code_first) else $error("diagnostic_code_first not stored");

  // Negative bus-bar codes weigh the raw value less two to the fourteenth
  property p_sum_term;
    sum_take && !scan_start
      |=> acc_r == $past(acc_r) + 20'($past(res_data.raw))
                   - (($past(res_data.bipolar) && $past(res_data.raw[13])) ? 20'h04000 : 20'h00000);
  endproperty
  a_sum_term: assert property (p_sum_term) else $error("sum term wrong");

  property p_total_hold;
    !scan_done |=> $stable(total_r) && $stable(clipped_r);
  endproperty
  a_total_hold: assert property (p_total_hold) else $error("total moved outside scan end");

  c_scan:  cover property (scan_start ##[1:50] scan_done);
  c_clip:  cover property (scan_done && clip_nxt);
  c_filt:  cover property (rd_take && filtered_readback_select && idx == mrr_pkg::IDX_CELL_THIRTEEN_CODE);
  c_error: cover property (pslverr_r);

endmodule

/* sim/mrr_tb.sv */
/*
 * Self-checking bench for the measurement result register bank.
 * Assumes the bank answers APB with one wait state and takes engine pulses on pclk.
 */
`timescale 1ns/1ps
module tb;
  // ==========================================================================
  // Signals
  logic              pclk;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [11:0]       paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              scan_start;
  logic              scan_done;
  logic              res_valid;
  mrr_pkg::mrr_res_s res_data;
  logic [15:0]       measure_enable_first;
  logic [3:0]        diagnostic_select_first;
  logic [3:0]        diagnostic_select_second;
  int                fails;
  int                checked;
  logic [31:0]       seed;
  // Reference model state
  logic [13:0]       m_c13r, m_c13f, m_c14r, m_c14f, m_blr, m_blf, m_d1, m_d2;
  logic [15:0]       m_tot, m_en;
  logic              m_filt;
  int                acc;

  mrr_result_regs mrr_result_regs_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scan_start(scan_start), .scan_done(scan_done), .res_valid(res_valid), .res_data(res_data),
    .measure_enable_first(measure_enable_first), .diagnostic_select_first(diagnostic_select_first),
    .diagnostic_select_second(diagnostic_select_second)
  );

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // ==========================================================================
  // Helpers
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task report_and_stop();
    if (fails == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Each transfer starts one edge later so no signal is assigned twice per step
  task apb(input logic [9:0] idx, input logic [1:0] lo, input logic w, input logic [31:0] d,
           output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= {idx, lo};
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task chk(input logic [9:0] idx, input logic [31:0] exp);
    logic [31:0] rd;
    logic        err;
    apb(idx, 2'b00, 1'b0, 32'h0, rd, err);
    cmp(rd, exp);
    cmp({31'h0, err}, 32'h0);
  endtask

  task wr(input logic [9:0] idx, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(idx, 2'b00, 1'b1, d, rd, err);
    cmp({31'h0, err}, 32'h0);
  endtask

  function logic [31:0] fld(input logic [13:0] r, input logic [13:0] f);
    return {16'h0, (m_filt ? f : r), 2'b00};
  endfunction

  task pulse(input logic done);
    @(posedge pclk);
    if (done) scan_done <= 1'b1;
    else scan_start <= 1'b1;
    @(posedge pclk);
    scan_done <= 1'b0;
    scan_start <= 1'b0;
    if (done) m_tot = (acc < 0) ? 16'h0 : ((acc >> 2) > 65535 ? 16'hffff : 16'(acc >> 2));
    else acc = 0;
  endtask

  task send(input mrr_pkg::mrr_kind_e k, input logic [3:0] ch, input logic [13:0] r, input logic bip,
            input logic current_sense_amplifier);
    logic [31:0] t;
    logic [13:0] f;
    t = xs();
    f = t[13:0];
    @(posedge pclk);
    res_valid <= 1'b1;
    res_data <= '{kind: k, chan: ch, raw: r, filt: f, bipolar: bip, current_sense_amplifier: current_sense_amplifier};
    @(posedge pclk);
    res_valid <= 1'b0;
    case (k)
      mrr_pkg::KIND_CELL: begin
        if (!current_sense_amplifier && m_en[ch]) begin
          acc += bip ? int'($signed(r)) : int'(r);
          if (ch == mrr_pkg::CHAN_CELL_THIRTEEN_CODE) {m_c13r, m_c13f} = {r, f};
          if (ch == mrr_pkg::CHAN_CELL_FOURTEEN_CODE) {m_c14r, m_c14f} = {r, f};
        end
      end
      mrr_pkg::KIND_BLOCK: if (m_en[mrr_pkg::BLOCK_EN_BIT]) {m_blr, m_blf} = {r, f};
      mrr_pkg::KIND_DIAGNOSTIC_CODE_FIRST: m_d1 = r;
      default: m_d2 = r;
    endcase
  endtask

  // ==========================================================================
  // Main sequence
  logic [15:0] en_tab [4] = '{16'hbfff, 16'hbfff, 16'h0aaa, 16'hbfff};
  logic [1:0]  md_tab [4] = '{2'd0, 2'd2, 2'd0, 2'd1};
  logic        fl_tab [4] = '{1'b0, 1'b1, 1'b1, 1'b0};

  initial begin
    logic [31:0] t, rd, cfg;
    logic        err, bip;
    logic [13:0] r;
    seed = 32'd50;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {scan_start, scan_done, res_valid} = '0;
    res_data = '0;
    {m_c13r, m_c13f, m_c14r, m_c14f, m_blr, m_blf, m_d1, m_d2, m_tot, m_en, m_filt} = '0;
    acc = 0;
    fails = 0;
    checked = 0;
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) chk(mrr_pkg::IDX_CELL_THIRTEEN_CODE + 10'(i), 32'h0);
    apb(10'h3ff, 2'b00, 1'b0, 32'h0, rd, err);
    cmp(rd, 32'h0);
    cmp({31'h0, err}, 32'h1);
    apb(mrr_pkg::IDX_CELL_THIRTEEN_CODE, 2'b01, 1'b0, 32'h0, rd, err);
    cmp({31'h0, err}, 32'h1);
    for (int s = 0; s < 4; s++) begin
      t = xs();
      cfg = {20'h0, t[11:4], 3'h0, fl_tab[s]};
      m_en = en_tab[s];
      m_filt = fl_tab[s];
      wr(mrr_pkg::IDX_MEAS_EN, {16'h0, m_en});
      wr(mrr_pkg::IDX_CONFIG, cfg);
      wr(mrr_pkg::IDX_CELL_THIRTEEN_CODE + 10'(s), xs());
      wr(mrr_pkg::IDX_TOTAL, xs());
      pulse(1'b0);
      for (int ch = 0; ch < mrr_pkg::NUM_CELLS; ch++) begin
        t = xs();
        bip = (md_tab[s] == 2'd1) || (md_tab[s] == 2'd2 && t[14]);
        r = (md_tab[s] == 2'd1) ? {1'b1, t[12:0]} : t[13:0];
        send(mrr_pkg::KIND_CELL, 4'(ch), r, bip, 1'b0);
      end
      t = xs();
      send(mrr_pkg::KIND_CELL, mrr_pkg::CHAN_CELL_THIRTEEN_CODE, t[13:0], 1'b0, 1'b1);
      t = xs();
      send(mrr_pkg::KIND_BLOCK, 4'h0, t[13:0], 1'b0, 1'b0);
      t = xs();
      send(mrr_pkg::KIND_DIAGNOSTIC_CODE_FIRST, 4'h0, t[13:0], 1'b0, 1'b0);
      t = xs();
      send(mrr_pkg::KIND_DIAGNOSTIC_CODE_SECOND, 4'h0, t[13:0], 1'b0, 1'b0);
      pulse(1'b1);
      chk(mrr_pkg::IDX_CELL_THIRTEEN_CODE, fld(m_c13r, m_c13f));
      chk(mrr_pkg::IDX_CELL_FOURTEEN_CODE, fld(m_c14r, m_c14f));
      chk(mrr_pkg::IDX_BLOCK, fld(m_blr, m_blf));
      chk(mrr_pkg::IDX_TOTAL, {16'h0, m_tot});
      chk(mrr_pkg::IDX_DIAGNOSTIC_CODE_FIRST, {16'h0, m_d1, 2'b00});
      chk(mrr_pkg::IDX_DIAGNOSTIC_CODE_SECOND, {16'h0, m_d2, 2'b00});
      chk(mrr_pkg::IDX_STATUS, {16'h0, 8'(s + 1), 6'h0, acc < 0, 1'b0});
      chk(mrr_pkg::IDX_CONFIG, cfg);
      cmp({16'h0, measure_enable_first}, {16'h0, m_en});
      cmp({28'h0, diagnostic_select_first}, {28'h0, cfg[7:4]});
      cmp({28'h0, diagnostic_select_second}, {28'h0, cfg[11:8]});
    end
    // Second reset with results loaded: the six result registers and the enable word return to zero
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) chk(mrr_pkg::IDX_CELL_THIRTEEN_CODE + 10'(i), 32'h0);
    cmp({16'h0, measure_enable_first}, 32'h0);
    report_and_stop();
  end
endmodule
